/* File: src/vplane_pkg.sv */
// Shared constants and helpers for the video plane register bank
package vplane_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [19:0] OFS_DISPLAY_CTRL  = 20'h80040;
  localparam logic [19:0] OFS_BUF0_BASE     = 20'h80044;
  localparam logic [19:0] OFS_WIDTH_STRIDE  = 20'h80048;
  localparam logic [19:0] OFS_BUF0_END      = 20'h8004C;
  localparam logic [19:0] OFS_WIN_TL        = 20'h80050;
  localparam logic [19:0] OFS_WIN_BR        = 20'h80054;
  localparam logic [19:0] OFS_SCALE         = 20'h80058;
  localparam logic [19:0] OFS_SCALE_INIT    = 20'h8005C;
  localparam logic [19:0] OFS_YUV           = 20'h80060;
  localparam logic [19:0] OFS_BUF1_BASE     = 20'h80064;
  localparam logic [19:0] OFS_BUF1_END      = 20'h80068;
  localparam logic [19:0] OFS_EDGE_CTRL     = 20'h80074;
  localparam logic [19:0] OFS_ALPHA_CTRL    = 20'h80080;

  // ----------------------------------------------------------------
  // Register indices into the storage array
  // ----------------------------------------------------------------
  localparam int NUM_REGS       = 13;
  localparam int IX_DISPLAY     = 0;
  localparam int IX_BUF0_BASE   = 1;
  localparam int IX_WIDTH       = 2;
  localparam int IX_BUF0_END    = 3;
  localparam int IX_WIN_TL      = 4;
  localparam int IX_WIN_BR      = 5;
  localparam int IX_SCALE       = 6;
  localparam int IX_SCALE_INIT  = 7;
  localparam int IX_YUV         = 8;
  localparam int IX_BUF1_BASE   = 9;
  localparam int IX_BUF1_END    = 10;
  localparam int IX_EDGE        = 11;
  localparam int IX_ALPHA       = 12;

  // Offset table, ordered by index
  localparam logic [19:0] REG_OFS [NUM_REGS] = '{
    OFS_DISPLAY_CTRL, OFS_BUF0_BASE, OFS_WIDTH_STRIDE, OFS_BUF0_END,
    OFS_WIN_TL, OFS_WIN_BR, OFS_SCALE, OFS_SCALE_INIT, OFS_YUV,
    OFS_BUF1_BASE, OFS_BUF1_END, OFS_EDGE_CTRL, OFS_ALPHA_CTRL};

  // ----------------------------------------------------------------
  // Writable bit masks and reset value
  // ----------------------------------------------------------------
  localparam logic [31:0] MASK_DISPLAY  = 32'h0007_7FF7;
  localparam logic [31:0] MASK_BUF_ADDR = 32'h0BFF_FFF0;
  localparam logic [31:0] MASK_WIDTH    = 32'h3FF0_3FF0;
  localparam logic [31:0] MASK_WINDOW   = 32'h07FF_07FF;
  localparam logic [31:0] MASK_SCALE    = 32'h8FFF_8FFF;
  localparam logic [31:0] MASK_INIT     = 32'h0FFF_0FFF;
  localparam logic [31:0] MASK_ALL      = 32'hFFFF_FFFF;
  localparam logic [31:0] MASK_EDGE     = 32'h0100_03FF;
  localparam logic [31:0] MASK_ALPHA    = 32'h1F03_0FFF;
  localparam logic [31:0] RESET_VALUE   = 32'h0000_0000;

  localparam logic [31:0] REG_MASK [NUM_REGS] = '{
    MASK_DISPLAY, MASK_BUF_ADDR, MASK_WIDTH, MASK_BUF_ADDR,
    MASK_WINDOW, MASK_WINDOW, MASK_SCALE, MASK_INIT, MASK_ALL,
    MASK_BUF_ADDR, MASK_BUF_ADDR, MASK_EDGE, MASK_ALPHA};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_PENDING    = 31;
  localparam int BIT_FROM_HOST  = 27;
  localparam int BIT_BUF_USED   = 15;
  localparam int BIT_DUAL_BUF   = 13;
  localparam int BIT_ROW_STORE  = 18;
  localparam int BIT_OUTLINE_ON = 24;
  localparam int BIT_V_SHRINK   = 31;
  localparam int BIT_H_SHRINK   = 15;
  localparam int BIT_ALPHA_SEL  = 28;
  localparam int BIT_FORCE_V    = 11;
  localparam int BIT_FORCE_H    = 10;
  localparam int BIT_V_INTERP   = 9;
  localparam int BIT_H_INTERP   = 8;
  localparam int BIT_KEY_ON     = 3;
  localparam int BIT_PLANE_ON   = 2;

  // Ratio used when a direction is forced to one half
  localparam logic [11:0] HALF_RATIO = 12'h800;

  // Empty-entry thresholds for the fetch FIFO request level
  localparam logic [3:0] LEVEL_0 = 4'h1;
  localparam logic [3:0] LEVEL_1 = 4'h3;
  localparam logic [3:0] LEVEL_2 = 4'h7;
  localparam logic [3:0] LEVEL_3 = 4'hB;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte-lane merge of write data into the old value
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Request level code to empty-entry threshold
  function automatic logic [3:0] fifo_level(input logic [1:0] code);
    logic [3:0] lvl;
    case (code)
      2'h0:    lvl = LEVEL_0;
      2'h1:    lvl = LEVEL_1;
      2'h2:    lvl = LEVEL_2;
      default: lvl = LEVEL_3;
    endcase
    return lvl;
  endfunction

  // One phase step: carry in bit 12, new phase below
  function automatic logic [12:0] phase_step(input logic [11:0] ph,
                                             input logic [11:0] ratio);
    return {1'b0, ph} + {1'b0, ratio};
  endfunction

endpackage

/* File: src/video_plane_scaler_regs.sv */
// Video overlay plane register bank with flip and scaler phase logic
module video_plane_scaler_regs
  import vplane_pkg::*;
(
  // Clock and reset
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RESETN,
  // Avalon-MM slave
  input  wire logic [19:0] I_AVS_ADDRESS,
  input  wire logic        I_AVS_READ,
  input  wire logic        I_AVS_WRITE,
  input  wire logic [31:0] I_AVS_WRITEDATA,
  input  wire logic [3:0]  I_AVS_BYTEENABLE,
  output logic      [31:0] O_AVS_READDATA,
  output logic             O_AVS_WAITREQUEST,
  // Display timing strobes and alpha FIFO empty count
  input  wire logic        I_FRAME_BOUNDARY,
  input  wire logic        I_LINE_START,
  input  wire logic        I_LINE_STEP,
  input  wire logic        I_PIXEL_STEP,
  input  wire logic [3:0]  I_ALPHA_FIFO_EMPTY,
  // Fetch setup
  output logic      [21:0] O_FETCH_BASE,
  output logic      [21:0] O_FETCH_END,
  output logic             O_FETCH_FROM_HOST,
  output logic             O_BUF_IN_USE,
  output logic      [9:0]  O_LINE_BYTES,
  output logic      [9:0]  O_LINE_STRIDE,
  // Window
  output logic      [10:0] O_WIN_TOP,
  output logic      [10:0] O_WIN_LEFT,
  output logic      [10:0] O_WIN_BOTTOM,
  output logic      [10:0] O_WIN_RIGHT,
  // Scaler
  output logic             O_VERT_SHRINK_PICK,
  output logic             O_HORIZ_SHRINK_PICK,
  output logic      [11:0] O_V_PHASE,
  output logic      [11:0] O_H_PHASE,
  output logic             O_V_CARRY,
  output logic             O_H_CARRY,
  // Colour and edge
  output logic      [31:0] O_YUV_CONSTANTS,
  output logic             O_ROW_STORE_ON,
  output logic             O_OUTLINE_DETECT_ON,
  output logic      [9:0]  O_OUTLINE_THRESHOLD,
  // Alpha plane
  output logic             O_ALPHA_CONST_SEL,
  output logic      [3:0]  O_ALPHA_CONST,
  output logic             O_ALPHA_FIFO_REQ,
  output logic             O_VERT_INTERP,
  output logic             O_HORIZ_INTERP,
  output logic      [3:0]  O_PAN_START,
  output logic             O_KEY_MATCH_ON,
  output logic             O_ALPHA_PLANE_ON,
  output logic      [1:0]  O_ALPHA_FORMAT
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0] regs_r   [NUM_REGS];  // Register storage
  logic [31:0] regs_nxt [NUM_REGS];
  logic        ack_r;                // Second cycle of a bus access
  logic        ack_nxt;
  logic [31:0] rdata_r;              // Registered read data
  logic [31:0] rdata_nxt;
  logic        hit;                  // Address maps to a register
  int          idx;                  // Index of the addressed register
  logic        wr_go;                // Write takes effect this edge
  logic [31:0] rd_value;             // Readback of addressed register
  logic        pend0_r, pend0_nxt;   // Flip pending, buffer 0
  logic        pend1_r, pend1_nxt;   // Flip pending, buffer 1
  logic        buf_r, buf_nxt;       // Buffer in use
  logic [21:0] fbase_r, fbase_nxt;   // Latched fetch base
  logic [21:0] fend_r, fend_nxt;     // Latched fetch end
  logic        fhost_r, fhost_nxt;   // Latched memory source
  logic [11:0] vph_r, vph_nxt;       // Vertical phase
  logic [11:0] hph_r, hph_nxt;       // Horizontal phase
  logic        vcy_r, vcy_nxt;       // Vertical carry pulse
  logic        hcy_r, hcy_nxt;       // Horizontal carry pulse
  logic [11:0] v_ratio;              // Effective vertical ratio
  logic [11:0] h_ratio;              // Effective horizontal ratio
  logic [12:0] v_sum;                // Vertical phase step
  logic [12:0] h_sum;                // Horizontal phase step
  logic        row_store;            // Row store enable
  logic        dual_buf;             // Double buffering enable

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Match the bus address against the offset table
  always_comb begin
    hit = 1'b0;
    idx = 0;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (I_AVS_ADDRESS == REG_OFS[i]) begin
        hit = 1'b1;
        idx = i;
      end
    end
  end

  // Control fields used across groups
  assign row_store = regs_r[IX_DISPLAY][BIT_ROW_STORE];
  assign dual_buf  = regs_r[IX_DISPLAY][BIT_DUAL_BUF];

  // ----------------------------------------------------------------
  // Bus handshake: one wait cycle per access
  // ----------------------------------------------------------------
  assign O_AVS_WAITREQUEST = (I_AVS_READ | I_AVS_WRITE) & ~ack_r;
  assign wr_go             = I_AVS_WRITE & ack_r & hit;

  // Readback, with status bits folded in
  always_comb begin
    rd_value = regs_r[idx];
    case (idx)
      IX_DISPLAY:   rd_value[BIT_BUF_USED] = buf_r;
      IX_BUF0_BASE: rd_value[BIT_PENDING]  = pend0_r;
      IX_BUF1_BASE: rd_value[BIT_PENDING]  = pend1_r;
      default:      rd_value = regs_r[idx];
    endcase
  end

  // Next state of the handshake and read data
  always_comb begin
    ack_nxt   = (I_AVS_READ | I_AVS_WRITE) & ~ack_r;
    // Unmapped addresses read as zero
    rdata_nxt = (I_AVS_READ && hit) ? rd_value : 32'h0000_0000;
  end

  // Register the handshake
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign O_AVS_READDATA = rdata_r;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Merge byte lanes, keep only writable bits
  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      regs_nxt[i] = regs_r[i];
    end
    if (wr_go) begin
      // Bits outside the register's writable mask are cleared, including the low nibble of buffer and width registers
      regs_nxt[idx] = merge_bytes(regs_r[idx], I_AVS_WRITEDATA,
                                  I_AVS_BYTEENABLE) & REG_MASK[idx];
      // Edge detection only sticks while row store is on
      if (idx == IX_EDGE && !row_store) begin
        regs_nxt[idx][BIT_OUTLINE_ON] = 1'b0;
      end
    end
  end

  // Store registers; all reset to zero
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_r[i] <= RESET_VALUE;
      end
    end else begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_r[i] <= regs_nxt[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Buffer flip
  // ----------------------------------------------------------------
  // Pending set by base writes, cleared at frame boundary
  always_comb begin
    pend0_nxt = pend0_r;
    pend1_nxt = pend1_r;
    buf_nxt   = buf_r;
    fbase_nxt = fbase_r;
    fend_nxt  = fend_r;
    fhost_nxt = fhost_r;
    if (I_FRAME_BOUNDARY) begin
      pend0_nxt = 1'b0;
      pend1_nxt = 1'b0;
      // Alternate buffers only when double buffering is on
      buf_nxt   = dual_buf ? ~buf_r : 1'b0;
      if (buf_nxt) begin
        fbase_nxt = regs_r[IX_BUF1_BASE][25:4];
        fend_nxt  = regs_r[IX_BUF1_END][25:4];
        fhost_nxt = regs_r[IX_BUF1_BASE][BIT_FROM_HOST];
      end else begin
        fbase_nxt = regs_r[IX_BUF0_BASE][25:4];
        fend_nxt  = regs_r[IX_BUF0_END][25:4];
        fhost_nxt = regs_r[IX_BUF0_BASE][BIT_FROM_HOST];
      end
    end
    // A write in the boundary cycle stays pending
    if (wr_go && idx == IX_BUF0_BASE) begin
      pend0_nxt = 1'b1;
    end
    if (wr_go && idx == IX_BUF1_BASE) begin
      pend1_nxt = 1'b1;
    end
  end

  // Register flip state
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      pend0_r <= 1'b0;
      pend1_r <= 1'b0;
      buf_r   <= 1'b0;
      fbase_r <= 22'h000000;
      fend_r  <= 22'h000000;
      fhost_r <= 1'b0;
    end else begin
      pend0_r <= pend0_nxt;
      pend1_r <= pend1_nxt;
      buf_r   <= buf_nxt;
      fbase_r <= fbase_nxt;
      fend_r  <= fend_nxt;
      fhost_r <= fhost_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Scaler phase accumulators
  // ----------------------------------------------------------------
  // Forced half overrides the programmed ratio
  assign v_ratio = regs_r[IX_ALPHA][BIT_FORCE_V]
                   ? HALF_RATIO : regs_r[IX_SCALE][27:16];
  assign h_ratio = regs_r[IX_ALPHA][BIT_FORCE_H]
                   ? HALF_RATIO : regs_r[IX_SCALE][11:0];
  assign v_sum   = phase_step(vph_r, v_ratio);
  assign h_sum   = phase_step(hph_r, h_ratio);

  // Load at frame or line start, then step per line or pixel
  always_comb begin
    vph_nxt = vph_r;
    hph_nxt = hph_r;
    vcy_nxt = 1'b0;
    hcy_nxt = 1'b0;
    if (I_FRAME_BOUNDARY) begin
      vph_nxt = regs_r[IX_SCALE_INIT][27:16];
    end else if (I_LINE_STEP) begin
      vph_nxt = v_sum[11:0];
      vcy_nxt = v_sum[12];
    end
    if (I_LINE_START) begin
      hph_nxt = regs_r[IX_SCALE_INIT][11:0];
    end else if (I_PIXEL_STEP) begin
      hph_nxt = h_sum[11:0];
      hcy_nxt = h_sum[12];
    end
  end

  // Register the accumulators
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      vph_r <= 12'h000;
      hph_r <= 12'h000;
      vcy_r <= 1'b0;
      hcy_r <= 1'b0;
    end else begin
      vph_r <= vph_nxt;
      hph_r <= hph_nxt;
      vcy_r <= vcy_nxt;
      hcy_r <= hcy_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign O_FETCH_BASE        = fbase_r;
  assign O_FETCH_END         = fend_r;
  assign O_FETCH_FROM_HOST   = fhost_r;
  assign O_BUF_IN_USE        = buf_r;
  assign O_LINE_BYTES        = regs_r[IX_WIDTH][29:20];
  assign O_LINE_STRIDE       = regs_r[IX_WIDTH][13:4];
  assign O_WIN_TOP           = regs_r[IX_WIN_TL][26:16];
  assign O_WIN_LEFT          = regs_r[IX_WIN_TL][10:0];
  assign O_WIN_BOTTOM        = regs_r[IX_WIN_BR][26:16];
  assign O_WIN_RIGHT         = regs_r[IX_WIN_BR][10:0];
  assign O_VERT_SHRINK_PICK  = regs_r[IX_SCALE][BIT_V_SHRINK];
  assign O_HORIZ_SHRINK_PICK = regs_r[IX_SCALE][BIT_H_SHRINK];
  assign O_V_PHASE           = vph_r;
  assign O_H_PHASE           = hph_r;
  assign O_V_CARRY           = vcy_r;
  assign O_H_CARRY           = hcy_r;
  assign O_YUV_CONSTANTS     = regs_r[IX_YUV];
  assign O_ROW_STORE_ON      = row_store;
  // Edge detection acts only with the row store on
  assign O_OUTLINE_DETECT_ON = regs_r[IX_EDGE][BIT_OUTLINE_ON]
                               & row_store;
  assign O_OUTLINE_THRESHOLD = regs_r[IX_EDGE][9:0];
  assign O_ALPHA_CONST_SEL   = regs_r[IX_ALPHA][BIT_ALPHA_SEL];
  // Constant is zero when per-pixel alpha is chosen
  assign O_ALPHA_CONST       = O_ALPHA_CONST_SEL
                               ? regs_r[IX_ALPHA][27:24] : 4'h0;
  // Fetch request once enough entries are empty
  assign O_ALPHA_FIFO_REQ    = I_ALPHA_FIFO_EMPTY >=
                               fifo_level(regs_r[IX_ALPHA][17:16]);
  assign O_VERT_INTERP       = regs_r[IX_ALPHA][BIT_V_INTERP];
  assign O_HORIZ_INTERP      = regs_r[IX_ALPHA][BIT_H_INTERP];
  assign O_PAN_START         = regs_r[IX_ALPHA][7:4];
  assign O_KEY_MATCH_ON      = regs_r[IX_ALPHA][BIT_KEY_ON];
  assign O_ALPHA_PLANE_ON    = regs_r[IX_ALPHA][BIT_PLANE_ON];
  assign O_ALPHA_FORMAT      = regs_r[IX_ALPHA][1:0];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESETN);

  a_pend_set: assert property (
    wr_go && idx == IX_BUF0_BASE |=> pend0_r)
    else $error("buffer 0 base write did not set pending");

  a_pend_clear: assert property (
    I_FRAME_BOUNDARY && !(wr_go && idx == IX_BUF1_BASE)
    |=> !pend1_r)
    else $error("frame boundary did not clear pending");

  a_low_nibble: assert property (
    I_AVS_READ && !O_AVS_WAITREQUEST && $past(hit)
    |-> O_AVS_READDATA[3:0] == 4'h0 || !(
        $past(idx) == IX_BUF0_BASE || $past(idx) == IX_BUF1_END))
    else $error("address low nibble read nonzero");

  a_edge_gate: assert property (
    wr_go && idx == IX_EDGE && !row_store
    |=> !regs_r[IX_EDGE][BIT_OUTLINE_ON])
    else $error("edge enable stuck without row store");

  a_fifo_full: assert property (
    I_ALPHA_FIFO_EMPTY >= 4'hB |-> O_ALPHA_FIFO_REQ)
    else $error("no fetch request at eleven empty");

  a_fifo_none: assert property (
    I_ALPHA_FIFO_EMPTY == 4'h0 |-> !O_ALPHA_FIFO_REQ)
    else $error("fetch request with no empty entry");

  a_force_half: assert property (
    regs_r[IX_ALPHA][BIT_FORCE_V] && I_LINE_STEP && !I_FRAME_BOUNDARY
    |=> O_V_PHASE == 12'($past(vph_r) + 12'h800))
    else $error("forced half vertical step wrong");

  a_phase_load: assert property (
    I_LINE_START |=> O_H_PHASE == $past(regs_r[IX_SCALE_INIT][11:0]))
    else $error("horizontal phase not loaded at line start");

  a_buf_toggle: assert property (
    I_FRAME_BOUNDARY && dual_buf |=> O_BUF_IN_USE != $past(buf_r))
    else $error("buffer did not alternate");

  a_wait_one: assert property (
    $rose(I_AVS_READ) |-> O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST)
    else $error("read answer not after one wait cycle");

endmodule

/* File: tb/video_plane_scaler_regs_tb_top.sv */
// Self-checking bench for the video plane register bank
module video_plane_scaler_regs_tb_top import vplane_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk, rst_n, rd, wr, wait_q, host, inuse, vsp, hsp, vc, hc;
  logic        row, odet, asel, req, vi, hi, key, pon;
  logic [3:0]  stb, be, empty, a_const, pan;  // Strobes: fb, ls, lst, ps
  logic [19:0] addr;
  logic [31:0] wdata, rdata, yuv, got;
  logic [21:0] fbase, fend;
  logic [9:0]  lbytes, lstride, othr;
  logic [10:0] wt, wl, wb, wrt;
  logic [11:0] vph, hph;
  logic [1:0]  afmt;
  logic [3:0]  thr [4] = '{4'h1, 4'h3, 4'h7, 4'hB};  // Request levels
  int          n_fail, checked;

  video_plane_scaler_regs dut_u (
    .I_CLK_SYS(clk), .I_RESETN(rst_n), .I_AVS_ADDRESS(addr),
    .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata),
    .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdata),
    .O_AVS_WAITREQUEST(wait_q), .I_FRAME_BOUNDARY(stb[0]),
    .I_LINE_START(stb[1]), .I_LINE_STEP(stb[2]), .I_PIXEL_STEP(stb[3]),
    .I_ALPHA_FIFO_EMPTY(empty), .O_FETCH_BASE(fbase), .O_FETCH_END(fend),
    .O_FETCH_FROM_HOST(host), .O_BUF_IN_USE(inuse), .O_LINE_BYTES(lbytes),
    .O_LINE_STRIDE(lstride), .O_WIN_TOP(wt), .O_WIN_LEFT(wl),
    .O_WIN_BOTTOM(wb), .O_WIN_RIGHT(wrt), .O_VERT_SHRINK_PICK(vsp),
    .O_HORIZ_SHRINK_PICK(hsp), .O_V_PHASE(vph), .O_H_PHASE(hph),
    .O_V_CARRY(vc), .O_H_CARRY(hc), .O_YUV_CONSTANTS(yuv),
    .O_ROW_STORE_ON(row), .O_OUTLINE_DETECT_ON(odet),
    .O_OUTLINE_THRESHOLD(othr), .O_ALPHA_CONST_SEL(asel),
    .O_ALPHA_CONST(a_const), .O_ALPHA_FIFO_REQ(req), .O_VERT_INTERP(vi),
    .O_HORIZ_INTERP(hi), .O_PAN_START(pan), .O_KEY_MATCH_ON(key),
    .O_ALPHA_PLANE_ON(pon), .O_ALPHA_FORMAT(afmt));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One Avalon access; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [19:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    be <= b;
    // Waitrequest is judged at rising edges only; watchdog ends a hang
    do begin
      @(posedge clk);
    end while (wait_q !== 1'b0);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    // Let the accepted write settle before outputs are compared
    @(negedge clk);
  endtask
  task automatic wreg(input logic [19:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask
  task automatic rchk(input logic [19:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(got, e);
  endtask
  // One-cycle pulse on the chosen strobes, then wait for settled outputs
  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    stb <= m;
    @(posedge clk);
    stb <= 4'h0;
    @(negedge clk);
  endtask
  // Prints the counts and the verdict, then ends the run
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, rd, wr, stb, be, empty, addr, wdata} = '0;
    n_fail = 0;
    checked = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < NUM_REGS; i++) rchk(REG_OFS[i], RESET_VALUE);
    // All ones, vertical kept expanding while the row store is on
    for (int i = 0; i < NUM_REGS; i++)
      wreg(REG_OFS[i], (i == IX_SCALE) ? 32'h7FFF_FFFF : 32'hFFFF_FFFF);
    // Writable bits read back, pending set on base writes
    for (int i = 0; i < NUM_REGS; i++) rchk(REG_OFS[i], REG_MASK[i] ^
      ((i == IX_BUF0_BASE || i == IX_BUF1_BASE || i == IX_SCALE) ?
      32'h8000_0000 : 32'h0000_0000));
    // Byte lanes and an unmapped place
    bus(1'b1, OFS_YUV, 32'h0, 4'h5);
    rchk(OFS_YUV, 32'hFF00_FF00);
    chk(yuv, 32'hFF00_FF00);
    wreg(20'h80070, 32'hFFFF_FFFF);
    rchk(20'h80070, 32'h0);
    // Double-buffered flip between the two frame buffers
    wreg(OFS_DISPLAY_CTRL, 32'h0004_2000);
    wreg(OFS_BUF0_BASE, 32'h0312_3450);
    wreg(OFS_BUF0_END, 32'h0000_FFF0);
    wreg(OFS_BUF1_BASE, 32'h0ABC_DEF0);
    wreg(OFS_BUF1_END, 32'h0000_1230);
    rchk(OFS_BUF1_BASE, 32'h8ABC_DEF0);
    pulse(4'h1);
    chk({inuse, host}, 2'b11);
    chk({fbase, fend[7:0]}, {22'h2BCDEF, 8'h23});
    rchk(OFS_BUF1_BASE, 32'h0ABC_DEF0);
    rchk(OFS_DISPLAY_CTRL, 32'h0004_A000);
    pulse(4'h1);
    chk({inuse, host}, 2'b00);
    chk({fbase, fend[9:0]}, {22'h312345, 10'h3FF});
    // Edge enable accepted while the row store is still on
    wreg(OFS_EDGE_CTRL, 32'h0100_0000);
    chk({row, odet, othr}, {2'b11, 10'h000});
    // Edge enable refused without the row store
    wreg(OFS_DISPLAY_CTRL, 32'h0);
    wreg(OFS_EDGE_CTRL, 32'hFFFF_FFFF);
    rchk(OFS_EDGE_CTRL, 32'h0000_03FF);
    chk({row, odet, othr}, {2'b00, 10'h3FF});
    // Field positions of plane setup
    wreg(OFS_WIDTH_STRIDE, 32'h2AB0_1550);
    wreg(OFS_WIN_TL, 32'h0123_0456);
    wreg(OFS_WIN_BR, 32'h0765_0321);
    chk({lbytes, lstride}, {10'h2AB, 10'h155});
    chk({wt, wl}, {11'h123, 11'h456});
    chk({wb, wrt}, {11'h765, 11'h321});
    wreg(OFS_ALPHA_CTRL, 32'h0A03_035E);
    chk({asel, a_const, vi, hi, pan}, 10'h035);
    chk({key, pon, afmt}, 4'hE);
    wreg(OFS_ALPHA_CTRL, 32'h1A00_0000);
    chk({asel, a_const}, 5'h1A);
    // Fetch request level for every code
    for (int c = 0; c < 4; c++) begin
      wreg(OFS_ALPHA_CTRL, 32'(c) << 16);
      @(posedge clk);
      empty <= thr[c] - 4'h1;
      @(negedge clk);
      chk(req, 1'b0);
      @(posedge clk);
      empty <= thr[c];
      @(negedge clk);
      chk(req, 1'b1);
    end
    // Phase accumulators, carries and forced half ratio
    wreg(OFS_ALPHA_CTRL, 32'h0);
    wreg(OFS_SCALE, 32'h8555_0C00);
    wreg(OFS_SCALE_INIT, 32'h0100_0700);
    chk({vsp, hsp}, 2'b10);
    pulse(4'h2);
    chk(hph, 12'h700);
    pulse(4'h8);
    chk({hc, hph}, 13'h1300);
    pulse(4'h8);
    chk({hc, hph}, 13'h0F00);
    wreg(OFS_ALPHA_CTRL, 32'h0000_0400);
    pulse(4'h8);
    chk({hc, hph}, 13'h1700);
    pulse(4'h1);
    chk(vph, 12'h100);
    pulse(4'h4);
    chk({vc, vph}, 13'h0655);
    wreg(OFS_ALPHA_CTRL, 32'h0000_0800);
    pulse(4'h4);
    chk({vc, vph}, 13'h0E55);
    tally_and_finish();
  end
endmodule
